// >>> dv/ssp_bus_partner.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_bus_partner (
    input wire logic i_mclk,
    input wire logic i_sck,
    input wire logic i_sck_oe,
    input wire logic i_sdo,
    input wire logic [7:0] i_reply,
    output logic o_sck,
    output logic o_sdi,
    output logic o_ss_n,
    output logic [7:0] o_seen
);
    int cnt = 0;
    logic [7:0] rep = 8'h00;
    logic [7:0] mdat = 8'h00;
    logic mst = 1'b0;
    logic idle_t = 1'b0;
    initial begin
        o_sck = 1'b0;
        o_ss_n = 1'b1;
        o_seen = 8'h00;
    end
    // Answer on the device clock edge itself, as a real shifter would
    always @(i_sck) begin
        if (i_sck_oe) begin
            cnt = cnt + 1;
            if (cnt % 2 == 1) o_seen = {o_seen[6:0], i_sdo};
            else rep = {rep[6:0], 1'b0};
            if (cnt == 16) begin
                cnt = 0;
                rep = i_reply;
            end
        end
    end
    always @(i_reply or negedge i_sck_oe) begin
        cnt = 0;
        rep = i_reply;
    end
    // Outside a frame the data line changes every cycle so no stale bit passes
    always @(posedge i_mclk) idle_t <= ~idle_t;
    assign o_sdi = i_sck_oe ? rep[7] : (mst ? mdat[7] : idle_t);
    // One byte as bus master, clock idle low, data set before the rising edge
    task automatic send(input logic [7:0] b, input logic sel);
        mdat <= b;
        mst <= 1'b1;
        o_ss_n <= ~sel;
        repeat (6) @(posedge i_mclk);
        repeat (8) begin
            o_sck <= 1'b1;
            repeat (6) @(posedge i_mclk);
            o_sck <= 1'b0;
            mdat <= {mdat[6:0], 1'b0};
            repeat (6) @(posedge i_mclk);
        end
        o_ss_n <= 1'b1;
        mst <= 1'b0;
        repeat (6) @(posedge i_mclk);
    endtask : send
endmodule : ssp_bus_partner
`default_nettype wire

// >>> dv/tb_sync_serial_port_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_sync_serial_port_control;
    import ssp_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    ssp_apb_req_s req = '0;
    logic tm = 1'b0, rxv = 1'b0, scl, sck_o, sck_oe, sdo, sdo_oe, scl_o, scl_oe;
    logic pready, pslverr, bit_tick, spi_own, i2c_own, psck, psdi, pss_n, sck_d;
    logic [7:0] rxb = 8'h00, reply = 8'h00, seen;
    logic [31:0] prdata, r;
    logic e;
    logic ce = 1'b1;
    ssp_i2c_cfg_s cfg;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    int ntog, gaps, since, half_exp, ntick, tgaps, tsince, tick_exp;
    // Clock line left as an input with a pull-up; the port can only pull it low
    assign scl = scl_oe ? scl_o : 1'b1;
    ssp_ctrl uut (.i_mclk(mclk), .i_rst_n(rst_n), .i_ce(ce), .i_apb(req), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_sck(psck), .o_sck(sck_o), .o_sck_oe(sck_oe),
        .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_sdi(psdi), .i_ss_n(pss_n), .i_scl(scl), .o_scl(scl_o),
        .o_scl_oe(scl_oe), .i_timer_match(tm), .i_i2c_rx_valid(rxv), .i_i2c_rx_byte(rxb),
        .o_i2c_cfg(cfg), .o_i2c_bit_tick(bit_tick), .o_spi_pins_owned(spi_own),
        .o_i2c_pins_owned(i2c_own));
    ssp_bus_partner u_far (.i_mclk(mclk), .i_sck(sck_o), .i_sck_oe(sck_oe), .i_sdo(sdo),
        .i_reply(reply), .o_sck(psck), .o_sdi(psdi), .o_ss_n(pss_n), .o_seen(seen));
    initial begin
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        tm <= (cyc % 4 == 0);
        if (cyc == 40000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    // Sampled on the falling edge, where every output has settled
    always @(negedge mclk) begin
        if (sck_o !== sck_d) begin
            ntog++;
            if (ntog > 1 && since != half_exp) gaps++;
            since = 1;
        end else since++;
        sck_d = sck_o;
        if (bit_tick === 1'b1) begin
            ntick++;
            if (ntick > 1 && tsince != tick_exp) tgaps++;
            tsince = 1;
        end else tsince++;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge mclk);
        req.penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, r);
    endtask : rdc
    task automatic wait_idle();
        do apb(1'b0, SSP_OFF_STAT, 32'h0); while (r[SSP_STAT_BUSY] !== 1'b0);
    endtask : wait_idle
    task automatic t_reset();
        rdc("ctrl reset", SSP_OFF_CTRL, 32'h0);
        rdc("baud reset", SSP_OFF_BAUD, 32'h0);
        rdc("stat reset", SSP_OFF_STAT, 32'h8);
        // Clock enable dropped in mid-transfer: the access phase must stall, then complete
        fork
            begin
                @(posedge mclk);
                ce <= 1'b0;
                repeat (4) @(posedge mclk);
                chk("stalled pready", 32'h0, {31'h0, pready});
                ce <= 1'b1;
            end
        join_none
        wr(SSP_OFF_BAUD, 32'h55);
        rdc("write after stall", SSP_OFF_BAUD, 32'h55);
        rdc("unmapped read", 8'h10, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("spi pins at reset", 32'h0, {31'h0, spi_own});
        $display("test reset done");
    endtask : t_reset
    task automatic t_spi_master();
        logic [3:0] md [5] = '{SSP_M_SPI_FOSC4, SSP_M_SPI_FOSC16, SSP_M_SPI_FOSC64, SSP_M_SPI_TMR, SSP_M_SPI_BAUD};
        int hf [5] = '{2, 8, 32, 4, 4};
        for (int i = 0; i < 5; i++) begin
            wr(SSP_OFF_BAUD, 32'h1);
            // Polarity changes while disabled, so the far side never sees a stray clock edge
            wr(SSP_OFF_CTRL, {26'h0, 1'b0, i[0], md[i]});
            wr(SSP_OFF_CTRL, {26'h0, 1'b1, i[0], md[i]});
            reply = 8'h3C + 8'(i);
            ntog = 0;
            gaps = 0;
            half_exp = hf[i];
            repeat (20) @(posedge mclk);
            chk("toggles before write", 32'h0, ntog);
            chk("sck idle", {31'h0, i[0]}, {31'h0, sck_o});
            chk("sck enable", 32'h1, {31'h0, sck_oe & spi_own});
            wr(SSP_OFF_BUF, 32'hA5 ^ i);
            wait_idle();
            chk("toggles", 32'h10, ntog);
            chk("half period", 32'h0, gaps);
            chk("sent byte", 32'hA5 ^ i, {24'h0, seen});
            chk("sck idle after", {31'h0, i[0]}, {31'h0, sck_o});
            if (hf[i] >= 8) rdc("received", SSP_OFF_BUF, {24'h0, reply});
        end
        wr(SSP_OFF_BUF, 32'h5A);
        wait_idle();
        rdc("no master overflow", SSP_OFF_CTRL, 32'h2A);
        wr(SSP_OFF_BAUD, 32'h0);
        apb(1'b0, SSP_OFF_STAT, 32'h0);
        chk("baud zero flagged", 32'h1, {31'h0, r[SSP_STAT_CFG_BAD]});
        wr(SSP_OFF_CTRL, 32'h0A);
        chk("pins released", 32'h0, {30'h0, spi_own, sck_oe});
        $display("test spi master done");
    endtask : t_spi_master
    task automatic t_spi_slave();
        apb(1'b0, SSP_OFF_BUF, 32'h0);
        wr(SSP_OFF_CTRL, 32'h24);
        u_far.send(8'h5A, 1'b1);
        u_far.send(8'hC3, 1'b1);
        rdc("slave overflow", SSP_OFF_CTRL, 32'h64);
        rdc("buffer kept", SSP_OFF_BUF, 32'h5A);
        wr(SSP_OFF_CTRL, 32'h24);
        rdc("overflow cleared", SSP_OFF_CTRL, 32'h24);
        wr(SSP_OFF_CTRL, 32'h25);
        u_far.send(8'h96, 1'b0);
        rdc("select ignored", SSP_OFF_BUF, 32'h96);
        chk("sdo driven", 32'h1, {31'h0, sdo_oe});
        wr(SSP_OFF_CTRL, 32'h24);
        u_far.send(8'h77, 1'b0);
        apb(1'b0, SSP_OFF_STAT, 32'h0);
        chk("not selected", 32'h0, {31'h0, r[SSP_STAT_FULL]});
        chk("sdo released", 32'h0, {31'h0, sdo_oe});
        $display("test spi slave done");
    endtask : t_spi_slave
    task automatic t_i2c();
        logic [3:0] md [6] = '{4'hF, 4'hE, 4'h7, 4'h6, 4'h8, 4'hB};
        logic [4:0] ex [6] = '{5'h13, 5'h11, 5'h12, 5'h10, 5'h08, 5'h04};
        for (int i = 0; i < 6; i++) begin
            wr(SSP_OFF_CTRL, {26'h0, 2'b10, md[i]});
            chk("i2c config", {27'h0, ex[i]}, {27'h0, cfg});
            chk("pin owners", 32'h2, {30'h0, i2c_own, spi_own});
            chk("stretch", {31'h0, ex[i][4]}, {31'h0, scl_oe});
            wr(SSP_OFF_CTRL, {28'h3, md[i]});
            chk("released", 32'h0, {31'h0, scl_oe});
        end
        wr(SSP_OFF_CTRL, 32'h26);
        apb(1'b0, SSP_OFF_BUF, 32'h0);
        for (int i = 1; i < 3; i++) begin
            rxb <= 8'(8'h11 * i);
            rxv <= 1'b1;
            @(posedge mclk);
            rxv <= 1'b0;
            @(posedge mclk);
        end
        rdc("i2c overflow", SSP_OFF_CTRL, 32'h66);
        rdc("i2c buffer kept", SSP_OFF_BUF, 32'h11);
        rdc("scl held low", SSP_OFF_STAT, 32'h0);
        wr(SSP_OFF_BAUD, 32'h3);
        wr(SSP_OFF_CTRL, 32'h28);
        ntick = 0;
        tgaps = 0;
        tick_exp = 8;
        repeat (60) @(posedge mclk);
        chk("bit ticks", 32'h1, {31'h0, ntick > 5});
        chk("bit tick gaps", 32'h0, tgaps);
        apb(1'b0, SSP_OFF_STAT, 32'h0);
        chk("baud 3 ok", 32'h0, {31'h0, r[SSP_STAT_CFG_BAD]});
        wr(SSP_OFF_BAUD, 32'h2);
        apb(1'b0, SSP_OFF_STAT, 32'h0);
        chk("baud 2 flagged", 32'h1, {31'h0, r[SSP_STAT_CFG_BAD]});
        $display("test i2c done");
    endtask : t_i2c
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_spi_master();
        t_spi_slave();
        t_i2c();
        give_verdict();
    end
endmodule : tb_sync_serial_port_control
`default_nettype wire

// >>> rtl/ssp_clkdiv.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_clkdiv (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_run,
    input wire logic [9:0] i_half,
    input wire logic i_use_ext,
    input wire logic i_ext_tick,
    output logic o_tick
);
    logic [9:0] cnt;
    logic wrap;

    assign wrap = (cnt >= i_half - 10'h001);
    assign o_tick = i_run && (i_use_ext ? i_ext_tick : wrap);

    // Counter restarts whenever the engine is idle so the first half period is full length
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= 10'h000;
        end else if (i_ce) begin
            if (!i_run || wrap) begin
                cnt <= 10'h000;
            end else begin
                cnt <= cnt + 10'h001;
            end
        end
    end
endmodule : ssp_clkdiv
`default_nettype wire

// >>> rtl/ssp_ctrl.sv
// Contract
// - SPI slave sets overflow when a byte completes while buffer is unread.
// - SPI master never sets the overflow flag.
// - SPI master starts a transfer only when software writes the buffer.
// - I2C sets overflow when a byte arrives while buffer still full.
// - SPI enable claims clock, data and select pins; clearing releases them.
// - I2C enable claims the data and clock lines.
// - SPI clock polarity bit sets the serial clock idle level.
// - Codes 1111/1110 select I2C slave 10/7-bit with start/stop interrupts.
// - Codes 0111/0110 select I2C slave 10/7-bit without start/stop interrupts.
// - Code 1000 is I2C master, fosc/(4*(baud+1)); baud 0..2 unsupported.
// - Code 1010 is SPI master, fosc/(4*(baud+1)); baud 0 unsupported.
`timescale 1ns/10ps
`default_nettype none
module ssp_ctrl (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire ssp_pkg::ssp_apb_req_s i_apb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_sck,
    output logic o_sck,
    output logic o_sck_oe,
    output logic o_sdo,
    output logic o_sdo_oe,
    input wire logic i_sdi,
    input wire logic i_ss_n,
    input wire logic i_scl,
    output logic o_scl,
    output logic o_scl_oe,
    input wire logic i_timer_match,
    input wire logic i_i2c_rx_valid,
    input wire logic [7:0] i_i2c_rx_byte,
    output ssp_pkg::ssp_i2c_cfg_s o_i2c_cfg,
    output logic o_i2c_bit_tick,
    output logic o_spi_pins_owned,
    output logic o_i2c_pins_owned
);
    import ssp_pkg::*;

    logic wcol, ovf, en, clock_polarity_bit;
    logic [3:0] mode;
    logic [7:0] baud;
    logic [7:0] rx_buf;
    logic buf_full;
    ssp_state_e state;
    logic [7:0] tx_sh, rx_sh;
    logic [3:0] edge_cnt;
    logic [2:0] bit_cnt;
    logic sck_q, sck_d;
    logic [3:0] pin_s;
    logic sck_s, sdi_s, ss_n_s, scl_s;
    logic spi_master, spi_slave, i2c_slave, i2c_any, slave_sel;
    logic cfg_bad, run_div, tick;
    logic [9:0] half, baud_half;
    logic acc, wr, rd, wr_ctrl, wr_buf, rd_buf, addr_ok;
    logic slave_lead, slave_trail, slave_done, master_done, byte_done;
    logic [7:0] byte_in;
    logic [31:0] next_rdata;

    ssp_sync #(.W(4)) u_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_async({i_sck, i_sdi, i_ss_n, i_scl}),
        .o_sync(pin_s)
    );
    assign {sck_s, sdi_s, ss_n_s, scl_s} = pin_s;

    // Mode decode
    assign spi_master = en && (mode == SSP_M_SPI_FOSC4 || mode == SSP_M_SPI_FOSC16 ||
        mode == SSP_M_SPI_FOSC64 || mode == SSP_M_SPI_TMR || mode == SSP_M_SPI_BAUD);
    assign spi_slave = en && (mode == SSP_M_SPI_SLV_SS || mode == SSP_M_SPI_SLV_NOSS);
    assign i2c_slave = en && (mode == SSP_M_I2C_SLV7 || mode == SSP_M_I2C_SLV10 ||
        mode == SSP_M_I2C_SLV7_SP || mode == SSP_M_I2C_SLV10_SP);
    assign o_i2c_cfg.slave = i2c_slave;
    assign o_i2c_cfg.master = en && mode == SSP_M_I2C_MST;
    assign o_i2c_cfg.fw_master = en && mode == SSP_M_I2C_FW;
    assign o_i2c_cfg.addr10 = i2c_slave && mode[0];
    assign o_i2c_cfg.start_stop_irq = i2c_slave && mode[3];
    assign i2c_any = i2c_slave || o_i2c_cfg.master || o_i2c_cfg.fw_master;
    // Select ignored in 0101; unselected slave neither shifts nor drives
    assign slave_sel = spi_slave && (mode == SSP_M_SPI_SLV_NOSS || !ss_n_s);

    // Baud setting outside the supported range is flagged, not corrected
    assign cfg_bad = (mode == SSP_M_I2C_MST && baud < SSP_I2C_BAUD_MIN) ||
        (mode == SSP_M_SPI_BAUD && baud == SSP_RST_BAUD);

    // Serial clock half period: fosc/(4*(baud+1)) gives 2*(baud+1) cycles per half
    assign baud_half = {9'({1'b0, baud} + 9'h001), 1'b0};
    always_comb begin
        half = SSP_HALF_FOSC4;
        if (mode == SSP_M_SPI_FOSC16) begin
            half = SSP_HALF_FOSC16;
        end else if (mode == SSP_M_SPI_FOSC64) begin
            half = SSP_HALF_FOSC64;
        end else if (mode == SSP_M_SPI_BAUD || mode == SSP_M_I2C_MST) begin
            half = baud_half;
        end
    end
    assign run_div = (spi_master && state == SSP_ST_SHIFT) || o_i2c_cfg.master;

    ssp_clkdiv u_div (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_run(run_div),
        .i_half(half),
        .i_use_ext(mode == SSP_M_SPI_TMR),
        .i_ext_tick(i_timer_match),
        .o_tick(tick)
    );
    assign o_i2c_bit_tick = tick && o_i2c_cfg.master;

    // APB slave: zero wait states, stalls only while the clock enable is low
    assign acc = i_apb.psel && i_apb.penable && i_ce;
    assign wr = acc && i_apb.pwrite;
    assign rd = acc && !i_apb.pwrite;
    assign addr_ok = i_apb.paddr == SSP_OFF_CTRL || i_apb.paddr == SSP_OFF_BAUD ||
        i_apb.paddr == SSP_OFF_BUF || i_apb.paddr == SSP_OFF_STAT;
    assign wr_ctrl = wr && i_apb.paddr == SSP_OFF_CTRL;
    assign wr_buf = wr && i_apb.paddr == SSP_OFF_BUF;
    assign rd_buf = rd && i_apb.paddr == SSP_OFF_BUF;
    assign o_pready = i_ce;
    assign o_pslverr = i_apb.psel && i_apb.penable && !addr_ok;

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (i_apb.paddr == SSP_OFF_CTRL) begin
            next_rdata[SSP_CTRL_WCOL] = wcol;
            next_rdata[SSP_CTRL_OVF] = ovf;
            next_rdata[SSP_CTRL_EN] = en;
            next_rdata[SSP_CTRL_CKP] = clock_polarity_bit;
            next_rdata[SSP_CTRL_MODE_LSB +: 4] = mode;
        end else if (i_apb.paddr == SSP_OFF_BAUD) begin
            next_rdata[7:0] = baud;
        end else if (i_apb.paddr == SSP_OFF_BUF) begin
            next_rdata[7:0] = rx_buf;
        end else if (i_apb.paddr == SSP_OFF_STAT) begin
            next_rdata[SSP_STAT_FULL] = buf_full;
            next_rdata[SSP_STAT_BUSY] = state == SSP_ST_SHIFT;
            next_rdata[SSP_STAT_CFG_BAD] = cfg_bad;
            next_rdata[SSP_STAT_SCL] = scl_s;
        end
    end

    // Read data is captured in the setup cycle
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (i_ce && i_apb.psel && !i_apb.penable) begin
            o_prdata <= next_rdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en <= 1'b0;
            clock_polarity_bit <= 1'b0;
            mode <= SSP_RST_MODE;
            baud <= SSP_RST_BAUD;
        end else if (wr_ctrl) begin
            en <= i_apb.pwdata[SSP_CTRL_EN];
            clock_polarity_bit <= i_apb.pwdata[SSP_CTRL_CKP];
            mode <= i_apb.pwdata[SSP_CTRL_MODE_LSB +: 4];
        end else if (wr && i_apb.paddr == SSP_OFF_BAUD) begin
            baud <= i_apb.pwdata[7:0];
        end
    end

    // SPI slave edge detect on the synchronised clock; leading edge leaves idle level
    assign slave_lead = slave_sel && sck_s != sck_d && sck_d == clock_polarity_bit;
    assign slave_trail = slave_sel && sck_s != sck_d && sck_d != clock_polarity_bit;
    assign slave_done = slave_lead && bit_cnt == SSP_LAST_BIT;
    assign master_done = spi_master && state == SSP_ST_SHIFT && tick && edge_cnt == SSP_LAST_EDGE;
    assign byte_done = i_ce && (master_done || slave_done || (i2c_any && i_i2c_rx_valid));
    assign byte_in = i2c_any ? i_i2c_rx_byte : (slave_done ? {rx_sh[6:0], sdi_s} : rx_sh);

    // Shift engine
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= SSP_ST_IDLE;
            tx_sh <= SSP_RST_BYTE;
            rx_sh <= SSP_RST_BYTE;
            edge_cnt <= 4'h0;
            bit_cnt <= 3'h0;
            sck_q <= 1'b0;
            sck_d <= 1'b1;
        end else if (i_ce) begin
            sck_d <= sck_s;
            if (!en) begin
                state <= SSP_ST_IDLE;
                edge_cnt <= 4'h0;
                bit_cnt <= 3'h0;
                sck_q <= clock_polarity_bit;
            end else if (spi_master) begin
                case (state)
                    SSP_ST_IDLE: begin
                        sck_q <= clock_polarity_bit;
                        if (wr_buf) begin
                            tx_sh <= i_apb.pwdata[7:0];
                            edge_cnt <= 4'h0;
                            state <= SSP_ST_SHIFT;
                        end
                    end
                    SSP_ST_SHIFT: begin
                        if (tick) begin
                            sck_q <= ~sck_q;
                            edge_cnt <= edge_cnt + 4'h1;
                            if (!edge_cnt[0]) begin
                                rx_sh <= {rx_sh[6:0], sdi_s};
                            end else begin
                                tx_sh <= {tx_sh[6:0], 1'b0};
                            end
                            if (edge_cnt == SSP_LAST_EDGE) begin
                                state <= SSP_ST_IDLE;
                            end
                        end
                    end
                    default: state <= SSP_ST_IDLE;
                endcase
            end else begin
                state <= SSP_ST_IDLE;
                if (wr_buf) begin
                    tx_sh <= i_apb.pwdata[7:0];
                end else if (slave_trail) begin
                    tx_sh <= {tx_sh[6:0], 1'b0};
                end
                if (!slave_sel) begin
                    bit_cnt <= 3'h0;
                end else if (slave_lead) begin
                    rx_sh <= {rx_sh[6:0], sdi_s};
                    bit_cnt <= bit_cnt + 3'h1;
                end
            end
        end
    end

    // Receive buffer and flags; a hardware set wins over a software clear
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_buf <= SSP_RST_BYTE;
            buf_full <= 1'b0;
            ovf <= 1'b0;
            wcol <= 1'b0;
        end else if (i_ce) begin
            if (byte_done && buf_full && !spi_master) begin
                ovf <= 1'b1;
            end else if (wr_ctrl && !i_apb.pwdata[SSP_CTRL_OVF]) begin
                ovf <= 1'b0;
            end
            // Master may overwrite: a new byte only follows a buffer write
            if (byte_done && (!buf_full || spi_master)) begin
                rx_buf <= byte_in;
                buf_full <= 1'b1;
            end else if (rd_buf) begin
                buf_full <= 1'b0;
            end
            if (wr_buf && state == SSP_ST_SHIFT) begin
                wcol <= 1'b1;
            end else if (wr_ctrl && !i_apb.pwdata[SSP_CTRL_WCOL]) begin
                wcol <= 1'b0;
            end
        end
    end

    // Pin ownership and drive
    assign o_spi_pins_owned = en && (spi_master || spi_slave);
    assign o_i2c_pins_owned = en && i2c_any;
    assign o_sck = sck_q;
    assign o_sck_oe = spi_master;
    assign o_sdo = tx_sh[7];
    assign o_sdo_oe = spi_master || slave_sel;
    assign o_scl = 1'b0;
    // Stretch holds the line low until software sets the polarity bit
    assign o_scl_oe = i2c_slave && !clock_polarity_bit;

    sequence s_master_start;
        spi_master && state == SSP_ST_IDLE && wr_buf;
    endsequence

    sequence s_full_again;
        byte_done && buf_full;
    endsequence

    a_master_start: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_master_start |=> state == SSP_ST_SHIFT) else $error("master did not start on buffer write");
    a_start_cause: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        $rose(state == SSP_ST_SHIFT) |-> $past(wr_buf)) else $error("transfer began without buffer write");
    a_slave_ovf: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_full_again ##0 spi_slave |=> ovf) else $error("slave overflow not flagged");
    a_i2c_ovf: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        s_full_again ##0 i2c_any |=> ovf && $stable(rx_buf)) else $error("i2c overflow not flagged");
    a_master_no_ovf: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        spi_master && $past(spi_master) |-> !$rose(ovf)) else $error("master raised overflow");
    a_pins_released: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !en |-> !o_sck_oe && !o_sdo_oe && !o_scl_oe && !o_spi_pins_owned) else $error("pins held while off");
    a_sck_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        spi_master && $past(spi_master) && state == SSP_ST_IDLE && $stable(clock_polarity_bit) && $past(i_ce)
        |-> o_sck == clock_polarity_bit) else $error("serial clock idle level wrong");
    a_clock_stretch: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        en && mode == SSP_M_I2C_SLV7 && !clock_polarity_bit |-> o_scl_oe && !o_scl) else $error("clock not stretched");
    a_start_stop_cfg: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        en && mode == SSP_M_I2C_SLV10_SP |-> o_i2c_cfg.addr10 && o_i2c_cfg.start_stop_irq)
        else $error("10-bit slave config wrong");
    a_no_sp_irq: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        en && mode == SSP_M_I2C_SLV7 |-> o_i2c_cfg.slave && !o_i2c_cfg.start_stop_irq && !o_i2c_cfg.addr10)
        else $error("7-bit slave config wrong");
    a_baud_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        mode == SSP_M_SPI_BAUD && baud == SSP_RST_BAUD |-> cfg_bad) else $error("unsupported baud not flagged");
endmodule : ssp_ctrl
`default_nettype wire

// >>> rtl/ssp_pkg.sv
package ssp_pkg;

    // Register byte offsets
    localparam logic [7:0] SSP_OFF_CTRL = 8'h00;
    localparam logic [7:0] SSP_OFF_BAUD = 8'h04;
    localparam logic [7:0] SSP_OFF_BUF = 8'h08;
    localparam logic [7:0] SSP_OFF_STAT = 8'h0C;

    // Control register field positions
    localparam int SSP_CTRL_WCOL = 7;
    localparam int SSP_CTRL_OVF = 6;
    localparam int SSP_CTRL_EN = 5;
    localparam int SSP_CTRL_CKP = 4;
    localparam int SSP_CTRL_MODE_LSB = 0;

    // Status register field positions
    localparam int SSP_STAT_FULL = 0;
    localparam int SSP_STAT_BUSY = 1;
    localparam int SSP_STAT_CFG_BAD = 2;
    localparam int SSP_STAT_SCL = 3;

    // Values after reset
    localparam logic [3:0] SSP_RST_MODE = 4'h0;
    localparam logic [7:0] SSP_RST_BAUD = 8'h00;
    localparam logic [7:0] SSP_RST_BYTE = 8'h00;

    // Operating mode codes
    localparam logic [3:0] SSP_M_SPI_FOSC4 = 4'h0;
    localparam logic [3:0] SSP_M_SPI_FOSC16 = 4'h1;
    localparam logic [3:0] SSP_M_SPI_FOSC64 = 4'h2;
    localparam logic [3:0] SSP_M_SPI_TMR = 4'h3;
    localparam logic [3:0] SSP_M_SPI_SLV_SS = 4'h4;
    localparam logic [3:0] SSP_M_SPI_SLV_NOSS = 4'h5;
    localparam logic [3:0] SSP_M_I2C_SLV7 = 4'h6;
    localparam logic [3:0] SSP_M_I2C_SLV10 = 4'h7;
    localparam logic [3:0] SSP_M_I2C_MST = 4'h8;
    localparam logic [3:0] SSP_M_SPI_BAUD = 4'hA;
    localparam logic [3:0] SSP_M_I2C_FW = 4'hB;
    localparam logic [3:0] SSP_M_I2C_SLV7_SP = 4'hE;
    localparam logic [3:0] SSP_M_I2C_SLV10_SP = 4'hF;

    // Half periods of the serial clock in system clock cycles, then the I2C baud minimum, last edge and last bit
    localparam logic [9:0] SSP_HALF_FOSC4 = 10'h002;
    localparam logic [9:0] SSP_HALF_FOSC16 = 10'h008;
    localparam logic [9:0] SSP_HALF_FOSC64 = 10'h020;
    localparam logic [7:0] SSP_I2C_BAUD_MIN = 8'h03;
    localparam logic [3:0] SSP_LAST_EDGE = 4'hF;
    localparam logic [2:0] SSP_LAST_BIT = 3'h7;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ssp_apb_req_s;

    // Configuration handed to the external I2C sequencer
    typedef struct packed {
        logic slave;
        logic master;
        logic fw_master;
        logic addr10;
        logic start_stop_irq;
    } ssp_i2c_cfg_s;

    typedef enum logic [1:0] {
        SSP_ST_IDLE = 2'b01,
        SSP_ST_SHIFT = 2'b10
    } ssp_state_e;

endpackage : ssp_pkg

// >>> rtl/ssp_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ssp_sync #(
    parameter int W = 1
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= '1;
            o_sync <= '1;
        end else if (i_ce) begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule : ssp_sync
`default_nettype wire
